/* shared/foc_pkg.sv */
package foc_pkg;
    // Clock rate
    localparam int unsigned CLK_MHZ        = 250;
    // Timing figures as documented
    localparam int unsigned SWITCH_US      = 50;
    localparam int unsigned ALL_OUT_US     = 100;
    localparam int unsigned COMM_LOSS_MS   = 2000;
    localparam int unsigned RESP_MS        = 4;
    localparam int unsigned PROC_US        = 1500;
    // Derived cycle counts (all exact, the longest fits in 32 bits)
    localparam longint unsigned SWITCH_CYC  = longint'(SWITCH_US) * CLK_MHZ;
    localparam longint unsigned COMM_LOSS_CYC = longint'(COMM_LOSS_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned RESP_CYC    = longint'(RESP_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned PROC_CYC    = longint'(PROC_US) * CLK_MHZ;
    // Output count and timer width
    localparam int unsigned N_OUT          = 16;
    localparam int unsigned TMR_W          = 32;
    localparam logic [TMR_W-1:0] TMR_ONE   = 32'h0000_0001;
    localparam logic [TMR_W-1:0] TMR_ZERO  = 32'h0000_0000;
    // Status byte fields
    localparam int unsigned STAT_W         = 8;
    localparam int unsigned STAT_COMM_LOSS = 0;
    localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;

    typedef struct packed {
        logic [N_OUT-1:0] data;
        logic [N_OUT-1:0] ctrl;
    } foc_cmd_t;

    typedef enum logic [1:0] {
        FOC_IDLE = 2'b00,
        FOC_APPLY = 2'b01,
        FOC_RESP = 2'b10
    } foc_state_t;
endpackage

/* design/foc_top.sv */
// Functional notes
// - All outputs change together, within 100 us
// - Data 0, control 0: output steady OFF
// - Data 1, control 0: output steady ON
// - Both bits 1: output inverse of phase
// - Wave outputs switch within 50 us, hold
// - 2.0 s without commands: all OFF, flag
// - Independent outputs, no glitches
// - Response starts within 4 ms of command
// - Set-outputs processing under 1.5 ms
// - Accepts 1000 toggling commands in 1.5 s
`timescale 1ns/1ps
module foc_top
    import foc_pkg::*;
#(
    parameter logic [TMR_W-1:0] COMM_LOSS_CYCLES = TMR_W'(COMM_LOSS_CYC)
) (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic               cmd_valid_i,
    input  wire foc_cmd_t           cmd_i,
    input  wire logic               line_phase_reference_i,
    output logic [N_OUT-1:0]        out_o,
    output logic [STAT_W-1:0]       status_o,
    output logic                    resp_start_o,
    output logic                    comm_loss_o
);

    foc_state_t             state_r;
    foc_state_t             state_nxt;
    foc_cmd_t               cfg_r;
    foc_cmd_t               pend_r;
    logic                   phase_w;
    logic                   loss_w;
    logic [N_OUT-1:0]       out_r;
    logic                   resp_r;
    logic [STAT_W-1:0]      stat_w;
    logic [N_OUT-1:0]       out_nxt;

    wire                    apply_w   = (state_r == FOC_APPLY);
    wire                    take_w    = cmd_valid_i && (state_r == FOC_IDLE);

    // Line phase brought into the clock domain; level moves on a seen edge
    foc_phase_sync phase_u (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .line_i    (line_phase_reference_i),
        .level_o   (phase_w)
    );

    // Any command frame, taken or refused, proves the link alive
    foc_watchdog #(
        .LIMIT (COMM_LOSS_CYCLES)
    ) dog_u (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .kick_i    (cmd_valid_i),
        .lost_o    (loss_w),
        .status_o  (stat_w)
    );

    // One decode cell per output, so each output is set on its own
    for (genvar g = 0; g < N_OUT; g++) begin : g_cell
        foc_out_cell cell_u (
            .data_i  (cfg_r.data[g]),
            .ctrl_i  (cfg_r.ctrl[g]),
            .phase_i (phase_w),
            .kill_i  (loss_w),
            .out_o   (out_nxt[g])
        );
    end

    always_comb begin
        case (state_r)
            FOC_IDLE:  state_nxt = cmd_valid_i ? FOC_APPLY : FOC_IDLE;
            FOC_APPLY: state_nxt = FOC_RESP;
            FOC_RESP:  state_nxt = FOC_IDLE;
            default:   state_nxt = FOC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_r      <= FOC_IDLE;
            out_r        <= '0;
            resp_r       <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            out_r        <= out_nxt;
            resp_r       <= (state_r == FOC_RESP);
        end
    end

    // Command capture; one command per three cycles, well within 1.5 ms
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pend_r <= '0;
            cfg_r  <= '0;
        end else begin
            if (take_w) begin
                pend_r <= cmd_i;
            end
            if (apply_w) begin
                cfg_r <= pend_r;
            end
        end
    end

    // Status and loss level are registers inside the watchdog
    assign out_o        = out_r;
    assign status_o     = stat_w;
    assign resp_start_o = resp_r;
    assign comm_loss_o  = loss_w;

endmodule // foc_top

// Decode of one output setting
// A lost link overrides every setting, wave outputs included
module foc_out_cell (
    input  wire logic data_i,
    input  wire logic ctrl_i,
    input  wire logic phase_i,
    input  wire logic kill_i,
    output logic      out_o
);

    logic [1:0] mode_w;
    logic       set_w;

    assign mode_w = {data_i, ctrl_i};

    always_comb begin
        case (mode_w)
            2'h0:    set_w = 1'h0;
            2'h2:    set_w = 1'h1;
            2'h3:    set_w = ~phase_i;
            2'h1:    set_w = phase_i;
            default: set_w = 1'h0;
        endcase
    end

    // Forced OFF while communication is lost
    assign out_o = kill_i ? 1'h0 : set_w;

endmodule // foc_out_cell

// Two-stage synchroniser for the line phase level
// The held level changes only on a detected edge, so a wave output
// keeps one state for the whole half cycle
module foc_phase_sync (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic line_i,
    output logic      level_o
);

    logic [1:0] sync_r;
    logic       level_r;
    logic       edge_w;

    // Only the second stage is read outside the synchroniser
    assign edge_w = sync_r[1] ^ level_r;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync_r  <= 2'h0;
            level_r <= 1'h0;
        end else begin
            sync_r <= {sync_r[0], line_i};
            if (edge_w) begin
                level_r <= sync_r[1];
            end
        end
    end

    assign level_o = level_r;

endmodule // foc_phase_sync

// Communication loss watchdog and module status byte
module foc_watchdog
    import foc_pkg::*;
#(
    parameter logic [TMR_W-1:0] LIMIT = TMR_W'(COMM_LOSS_CYC)
) (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic              kick_i,
    output logic                   lost_o,
    output logic [STAT_W-1:0]      status_o
);

    logic [TMR_W-1:0]  cnt_r;
    logic              lost_r;
    logic [STAT_W-1:0] stat_r;
    logic              hit_w;

    // Count parks one below the limit (LIMIT - 1) so a long silence cannot wrap it
    assign hit_w = (cnt_r == LIMIT - TMR_ONE);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cnt_r  <= TMR_ZERO;
            lost_r <= 1'h0;
            stat_r <= STAT_RESET;
        end else if (kick_i) begin
            cnt_r  <= TMR_ZERO;
            lost_r <= 1'h0;
            stat_r[STAT_COMM_LOSS] <= 1'h0;
        end else if (hit_w) begin
            lost_r <= 1'h1;
            stat_r[STAT_COMM_LOSS] <= 1'h1;
        end else if (!lost_r) begin
            cnt_r <= cnt_r + TMR_ONE;
        end
    end

    assign lost_o   = lost_r;
    assign status_o = stat_r;

endmodule // foc_watchdog

/* tb/foc_cpu_model.sv */
`timescale 1ns/1ps
module foc_cpu_model
    import foc_pkg::*;
(
    input  wire logic sys_clk_i,
    output logic      cmd_valid_o = 1'b0,
    output foc_cmd_t  cmd_o = '0,
    output logic      phase_o = 1'b0
);
    task automatic send(input logic [15:0] d, c);
        @(negedge sys_clk_i);
        cmd_valid_o = 1'b1;
        cmd_o = '{d, c};
        @(negedge sys_clk_i);
        cmd_valid_o = 1'b0;
        cmd_o = ~cmd_o;
        repeat (2) @(negedge sys_clk_i);
    endtask
    task automatic flip_phase();
        phase_o = ~phase_o;
    endtask
endmodule // foc_cpu_model

/* tb/foc_chk.sv */
`timescale 1ns/1ps
module foc_chk
    import foc_pkg::*;
#(
    parameter int LOSS = 50
) (
    input wire logic              sys_clk_i,
    input wire logic              reset_i,
    input wire logic              cmd_valid_i,
    input wire foc_cmd_t          cmd_i,
    input wire logic              line_phase_reference_i,
    input wire logic [N_OUT-1:0]  out_o,
    input wire logic [STAT_W-1:0] status_o,
    input wire logic              resp_start_o,
    input wire logic              comm_loss_o
);
    wire ph = line_phase_reference_i;
    logic [31:0] idle_r;
    foc_cmd_t    cfg_r;
    always_ff @(posedge sys_clk_i) begin
        idle_r <= (reset_i || cmd_valid_i) ? '0 : idle_r + 1;
        cfg_r <= reset_i ? '0 : (cmd_valid_i ? cmd_i : cfg_r);
    end
    wire calm = idle_r > 4 && idle_r < LOSS - 9;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_out_config: assert property (calm && ph == $past(ph, 6) |->
        out_o == (cfg_r.data ^ (cfg_r.ctrl & {N_OUT{ph}}))) else $error("output");
    a_wave_switch: assert property ($changed(ph) && calm && cfg_r.ctrl != '0 |->
        ##[1:8] $changed(out_o)) else $error("switch");
    a_resp_time: assert property (cmd_valid_i |-> ##3 resp_start_o) else $error("resp");
    a_resp_pulse: assert property (resp_start_o |=> !resp_start_o) else $error("pulse");
    a_steady_cmd: assert property (cmd_valid_i && cmd_i.ctrl == '0 |->
        ##3 out_o == $past(cmd_i.data, 3)) else $error("steady");
    a_loss_time: assert property (idle_r == LOSS + 3 |-> comm_loss_o) else $error("loss");
    a_loss_off: assert property (comm_loss_o ##1 comm_loss_o |-> out_o == '0)
        else $error("off");
    a_loss_flag: assert property ($rose(comm_loss_o) |-> ##[0:1] status_o[STAT_COMM_LOSS])
        else $error("flag");
    cover property (comm_loss_o);
    cover property (calm && $changed(ph) && cfg_r.ctrl != '0);
    cover property (resp_start_o);
endmodule // foc_chk
bind foc_top foc_chk #(.LOSS(COMM_LOSS_CYCLES)) chk_u (
    .sys_clk_i              (sys_clk_i),
    .reset_i                (reset_i),
    .cmd_valid_i            (cmd_valid_i),
    .cmd_i                  (cmd_i),
    .line_phase_reference_i (line_phase_reference_i),
    .out_o                  (out_o),
    .status_o               (status_o),
    .resp_start_o           (resp_start_o),
    .comm_loss_o            (comm_loss_o)
);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import foc_pkg::*;
;
    localparam int LOSS = 50;
    logic              sys_clk_i = 1'b0;
    logic              reset_i = 1'b1;
    logic              cmd_valid_i;
    logic              line_phase_reference_i;
    foc_cmd_t          cmd_i;
    logic [N_OUT-1:0]  out_o;
    logic [STAT_W-1:0] status_o;
    logic              resp_start_o;
    logic              comm_loss_o;
    int                miscompares = 0;
    int                samples_checked = 0;
    foc_cpu_model cpu (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
        .phase_o(line_phase_reference_i));
    foc_top #(.COMM_LOSS_CYCLES(LOSS)) dut_u (
        .sys_clk_i              (sys_clk_i),
        .reset_i                (reset_i),
        .cmd_valid_i            (cmd_valid_i),
        .cmd_i                  (cmd_i),
        .line_phase_reference_i (line_phase_reference_i),
        .out_o                  (out_o),
        .status_o               (status_o),
        .resp_start_o           (resp_start_o),
        .comm_loss_o            (comm_loss_o)
    );
    task automatic chk(input logic [31:0] got, exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic t_modes();
        for (int p = 0; p < 2; p++) begin
            cpu.send(16'h0F0F, 16'h3333);
            chk(resp_start_o, 1'b1, "resp");
            @(negedge sys_clk_i);
            chk(resp_start_o, 1'b0, "resp end");
            repeat (8) @(negedge sys_clk_i);
            cpu.flip_phase();
            repeat (8) @(negedge sys_clk_i);
            chk(out_o, 16'h0F0F ^ (16'h3333 & {16{~p[0]}}), "mode");
        end
    endtask
    task automatic t_toggle();
        for (int i = 0; i < 10; i++) begin
            cpu.send({16{i[0]}}, 16'h0000);
            chk(out_o, {16{i[0]}}, "toggle");
        end
    endtask
    task automatic t_loss();
        repeat (LOSS + 6) @(negedge sys_clk_i);
        chk({comm_loss_o, status_o, out_o}, 25'h1010000, "loss");
        cpu.send(16'hFFFF, 16'h0000);
        chk({comm_loss_o, status_o, out_o}, 25'h000FFFF, "back");
    endtask
    task automatic t_reset();
        @(negedge sys_clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk({comm_loss_o, resp_start_o, status_o, out_o}, 26'h0, "in reset");
        reset_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk({comm_loss_o, resp_start_o, status_o, out_o}, 26'h0, "released");
        cpu.send(16'h00FF, 16'h0000);
        chk(out_o, 16'h00FF, "first cmd");
    endtask
    initial forever #2 sys_clk_i = ~sys_clk_i;
    initial begin
        #80000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (4) @(negedge sys_clk_i);
        reset_i = 1'b0;
        t_modes();
        t_toggle();
        t_loss();
        t_reset();
        end_sim();
    end
endmodule // tb_top
